// ===== scs_sequencer.sv
// Converter sequencer: AHB-Lite registers, prescaler, start logic, conversion timing, results
//
// Added by the designer: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/1ps
`include "scs_params.svh"
// ==========================================================================
// What this block does
// R1 - Right-align by default, left-align on select
// R2 - Low-byte read blocks result updates
// R3 - High-byte read lifts the update block
// R4 - Completion event fires even when discarded
// R5 - Start bit starts, stays set, self-clears
// R6 - Channel change waits for conversion end
// R7 - Auto trigger edge resets prescaler, starts
// R8 - Only rising edges start; busy edges ignored
// R9 - Software clears flag trigger before next
// R10 - Flag source means free running mode
// R11 - Start bit works, reads busy always
// R12 - Prescaler runs only while enabled
// R13 - Selections applied only while enabled
// R14 - Start waits next converter clock rise
// R15 - Thirteen cycles, 13.5 when auto triggered, twenty-five for first
// R16 - Sample at 1.5, first at 13.5
// R17 - Completion writes result, flag, clears start
// R18 - Auto sample two cycles after trigger
// R19 - Differential auto needs re-enable each time
// R20 - Free running restarts, start bit held
// R21 - Software keeps converter clock in range
// R22 - Software disables before sleep
// R23 - Selections track, freeze, resume at end
// R24 - Power-of-two prescaler from select field
module scs_sequencer
  import scs_pkg::*;
#(
  parameter int ADDR_W = 8,
  parameter int TRIG_W = 8,
  parameter int PRESC_W = 8
) (
  input wire logic clk_sys, // 40 MHz system clock
  input wire logic rst_n, // Synchronous reset, active low
  input wire logic ce, // Clock enable, freezes state when low
  input wire logic hsel, // AHB slave select
  input wire logic [ADDR_W-1:0] haddr, // AHB address
  input wire logic [1:0] htrans, // AHB transfer type
  input wire logic hwrite, // AHB write
  input wire logic [2:0] hsize, // AHB size, word only
  input wire logic [31:0] hwdata, // AHB write data
  input wire logic hready, // AHB bus ready
  output logic [31:0] hrdata, // AHB read data
  output logic hreadyout, // AHB slave ready
  output logic hresp, // AHB response, always OKAY
  input wire logic [TRIG_W-1:0] trig_in, // Auto trigger sources, bit 0 unused
  input wire scs_result_t sar_data, // Result from analog core
  output logic conv_clk, // Prescaled converter clock
  output logic sample_hold, // Sample-and-hold pulse
  output logic conv_busy, // Conversion in progress
  output logic [4:0] channel_select, // Applied channel selection
  output logic [1:0] reference_select, // Applied reference selection
  output logic conv_done // Completion event pulse
);
  // ========================================================================
  // Registers and state
  logic converter_enable;
  logic start_conversion_bit;
  logic auto_trigger_enable;
  logic conversion_complete_flag;
  logic [2:0] prescaler_select;
  logic [7:0] input_selection_register;
  logic [2:0] trigger_source_select;
  logic [7:0] result_low_byte;
  logic [7:0] result_high_byte;
  logic result_lock;
  logic first_pend;
  logic [1:0] conv_kind;
  logic [PRESC_W-1:0] presc_cnt;
  logic [5:0] half_cnt;
  logic [`SCS_TRIG_SYNC_STAGES-1:0] trig_pipe;
  logic trig_prev;
  scs_state_e state;

  // ========================================================================
  // Bus decode
  wire bus_go = hsel & hready & htrans[1] & ce;
  wire [ADDR_W-1:0] off = haddr;
  logic wr_pend;
  logic [ADDR_W-1:0] wr_off;
  wire wr_now = wr_pend & ce;
  wire wr_ctrl = wr_now && wr_off == ADDR_W'(`SCS_OFF_CTRL);
  wire wr_sel = wr_now && wr_off == ADDR_W'(`SCS_OFF_SEL);
  wire wr_spec = wr_now && wr_off == ADDR_W'(`SCS_OFF_SPECIAL);
  wire rd_go = bus_go & ~hwrite;
  wire rd_lo = rd_go && off == ADDR_W'(`SCS_OFF_RES_LO);
  wire rd_hi = rd_go && off == ADDR_W'(`SCS_OFF_RES_HI);
  wire [7:0] ctrl_rd = {converter_enable, start_conversion_bit, auto_trigger_enable,
                        conversion_complete_flag, 1'b0, prescaler_select};
  wire [7:0] rd_byte = off == ADDR_W'(`SCS_OFF_CTRL) ? ctrl_rd :
                       off == ADDR_W'(`SCS_OFF_SEL) ? input_selection_register :
                       off == ADDR_W'(`SCS_OFF_RES_LO) ? result_low_byte :
                       off == ADDR_W'(`SCS_OFF_RES_HI) ? result_high_byte :
                       off == ADDR_W'(`SCS_OFF_SPECIAL) ? {trigger_source_select, 5'h0} : 8'h00;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      wr_pend <= 1'b0;
      wr_off <= '0;
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else if (ce) begin
      wr_pend <= bus_go & hwrite;
      wr_off <= bus_go ? off : wr_off;
      hrdata <= rd_go ? {24'h00_0000, rd_byte} : hrdata;
    end
  end

  // ========================================================================
  // Prescaler and converter clock
  // Last count of a 2 << sel divide, one bit wider so divide by 256 fits
  function automatic logic [PRESC_W-1:0] presc_last(input logic [2:0] sel);
    presc_last = PRESC_W'(((PRESC_W+1)'(2) << sel) - (PRESC_W+1)'(1));
  endfunction

  wire [PRESC_W-1:0] div_last = presc_last(prescaler_select);
  wire [PRESC_W-1:0] half_last = div_last >> 1;
  wire rise_tick = converter_enable && presc_cnt == div_last; // R24
  wire fall_tick = converter_enable && presc_cnt == half_last;
  wire half_tick = rise_tick | fall_tick;

  // ========================================================================
  // Trigger edge detection and start decisions
  wire free_run = auto_trigger_enable && trigger_source_select == `SCS_SRC_FREE_RUN; // R10
  wire trig_sel = trig_in[trigger_source_select];
  wire trig_edge = trig_pipe[`SCS_TRIG_SYNC_STAGES-1] & ~trig_prev; // R8
  wire is_idle = state == SCS_IDLE;
  wire auto_go = is_idle & converter_enable & auto_trigger_enable & ~free_run & trig_edge; // R7
  wire manual_go = state == SCS_PEND & rise_tick; // R14
  wire [5:0] sh_at = conv_kind == 2'd1 ? `SCS_HALF_SH_FIRST :
                     conv_kind == 2'd2 ? `SCS_HALF_SH_AUTO : `SCS_HALF_SH_NORMAL; // R16 R18
  wire [5:0] end_at = conv_kind == 2'd1 ? `SCS_HALF_END_FIRST :
                      conv_kind == 2'd2 ? `SCS_HALF_END_AUTO : `SCS_HALF_END_NORMAL; // R15
  wire [5:0] half_nxt = half_cnt + 6'h01;
  wire conv_end = state == SCS_CONV & half_tick & half_nxt == end_at;
  wire sh_now = state == SCS_CONV & half_tick & half_nxt == sh_at;
  wire locked = state == SCS_CONV && half_cnt < end_at - 6'h02; // R23
  // Left align puts the top eight bits in the high byte
  wire [15:0] fmt = input_selection_register[`SCS_SEL_LEFT] ?
                    {sar_data, 6'h00} : {6'h00, sar_data}; // R1
  wire start_wr = wr_ctrl & hwdata[`SCS_CTRL_START] & hwdata[`SCS_CTRL_ENABLE];
  // Enable as it stands after this edge, so a disabling write aborts at once
  wire en_next = wr_ctrl ? hwdata[`SCS_CTRL_ENABLE] : converter_enable;

  scs_state_e next_state;
  always_comb begin
    next_state = state;
    case (state)
      SCS_IDLE: begin
        if (auto_go) begin
          next_state = SCS_CONV;
        end else if (start_conversion_bit && converter_enable) begin
          next_state = SCS_PEND;
        end
      end
      SCS_PEND: begin
        if (manual_go) begin
          next_state = SCS_CONV;
        end
      end
      SCS_CONV: begin
        if (conv_end && !free_run) begin
          next_state = SCS_IDLE; // R20
        end
      end
      default: next_state = SCS_IDLE;
    endcase
    if (!converter_enable || !en_next) begin
      next_state = SCS_IDLE;
    end
  end

  // ========================================================================
  // Sequencer state
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state <= SCS_IDLE;
      half_cnt <= 6'h00;
      conv_kind <= 2'd0;
      first_pend <= 1'b0;
      presc_cnt <= '0;
      trig_pipe <= '0;
      trig_prev <= 1'b0;
    end else if (ce) begin
      state <= next_state;
      trig_pipe <= {trig_pipe[`SCS_TRIG_SYNC_STAGES-2:0], trig_sel};
      trig_prev <= trig_pipe[`SCS_TRIG_SYNC_STAGES-1];
      if (!converter_enable || auto_go || rise_tick) begin
        presc_cnt <= '0; // R12 R7
      end else begin
        presc_cnt <= presc_cnt + PRESC_W'(1);
      end
      if (!converter_enable) begin
        first_pend <= 1'b1; // R19
      end else if (auto_go || manual_go) begin
        first_pend <= 1'b0;
      end
      if (auto_go || manual_go || (conv_end && free_run)) begin
        half_cnt <= 6'h00;
        conv_kind <= first_pend & (auto_go | manual_go) ? 2'd1 : auto_go ? 2'd2 : 2'd0;
      end else if (state == SCS_CONV && half_tick) begin
        half_cnt <= half_nxt;
      end
    end
  end

  // ========================================================================
  // Software registers, flag, result lock
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      {converter_enable, start_conversion_bit, auto_trigger_enable} <= 3'b000;
      conversion_complete_flag <= 1'b0;
      prescaler_select <= 3'(`SCS_CTRL_RESET >> `SCS_CTRL_PRESC_LSB);
      input_selection_register <= `SCS_SEL_RESET;
      trigger_source_select <= 3'(`SCS_SPECIAL_RESET >> `SCS_SPECIAL_TRIG_LSB);
      result_low_byte <= 8'h00;
      result_high_byte <= 8'h00;
      result_lock <= 1'b0;
    end else if (ce) begin
      if (wr_ctrl) begin
        converter_enable <= hwdata[`SCS_CTRL_ENABLE];
        auto_trigger_enable <= hwdata[`SCS_CTRL_AUTO];
        prescaler_select <= hwdata[`SCS_CTRL_PRESC_LSB +: 3];
      end
      if (wr_sel) begin
        input_selection_register <= hwdata[7:0];
      end
      if (wr_spec) begin
        trigger_source_select <= hwdata[`SCS_SPECIAL_TRIG_LSB +: 3];
      end
      // Start bit: busy or pending reads one; cleared on completion unless free running
      if (!en_next) begin
        start_conversion_bit <= 1'b0;
      end else if (start_wr || auto_go) begin
        start_conversion_bit <= 1'b1; // R5 R11
      end else if (conv_end && !free_run) begin
        start_conversion_bit <= 1'b0; // R17
      end
      // Hardware set wins over a write-one clear in the same cycle
      if (conv_end) begin
        conversion_complete_flag <= 1'b1; // R4
      end else if (wr_ctrl && hwdata[`SCS_CTRL_FLAG]) begin
        conversion_complete_flag <= 1'b0;
      end
      if (conv_end && !result_lock) begin
        result_low_byte <= fmt[7:0]; // R17
        result_high_byte <= fmt[15:8];
      end
      if (rd_hi) begin
        result_lock <= 1'b0; // R3
      end else if (rd_lo) begin
        result_lock <= 1'b1; // R2
      end
    end
  end

  // ========================================================================
  // Outputs towards the analog core
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      conv_clk <= 1'b0;
      sample_hold <= 1'b0;
      conv_busy <= 1'b0;
      conv_done <= 1'b0;
      channel_select <= 5'h00;
      reference_select <= 2'h0;
    end else if (ce) begin
      conv_clk <= !converter_enable ? 1'b0 : rise_tick ? 1'b1 : fall_tick ? 1'b0 : conv_clk;
      sample_hold <= sh_now; // R16
      conv_busy <= next_state == SCS_CONV;
      conv_done <= conv_end; // R4
      // Held during a conversion until two half cycles before its end so a mid-conversion change waits
      if (converter_enable && !locked) begin
        channel_select <= input_selection_register[`SCS_SEL_CHAN_LSB +: 5]; // R6 R13 R23
        reference_select <= input_selection_register[`SCS_SEL_REF_LSB +: 2];
      end
    end
  end

  // ========================================================================
  // Checks
  logic [5:0] sh_mark;
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      sh_mark <= 6'h00;
    end else if (ce && sh_now) begin
      sh_mark <= half_nxt;
    end
  end

  property p_done_flag;
    @(posedge clk_sys) disable iff (!rst_n)
      conv_end && ce |=> conversion_complete_flag && conv_done;
  endproperty
  a_done_flag: assert property (p_done_flag) else $error("flag not set at end"); // R4

  property p_align;
    @(posedge clk_sys) disable iff (!rst_n)
      ce && conv_end && !result_lock |=> $past(input_selection_register[`SCS_SEL_LEFT]) ?
        result_high_byte == $past(sar_data[9:2]) : result_low_byte == $past(sar_data[7:0]);
  endproperty
  a_align: assert property (p_align) else $error("result misaligned"); // R1

  property p_off_idle;
    @(posedge clk_sys) disable iff (!rst_n)
      ce && !en_next |=> state == SCS_IDLE && !start_conversion_bit && !conv_busy;
  endproperty
  a_off_idle: assert property (p_off_idle) else $error("converter active while off"); // R12

  property p_lock_holds;
    @(posedge clk_sys) disable iff (!rst_n)
      result_lock && conv_end && ce |=> $stable(result_low_byte) && $stable(result_high_byte);
  endproperty
  a_lock_holds: assert property (p_lock_holds) else $error("locked result changed"); // R2

  property p_unlock;
    @(posedge clk_sys) disable iff (!rst_n)
      rd_hi |=> !result_lock;
  endproperty
  a_unlock: assert property (p_unlock) else $error("high read left lock"); // R3

  property p_start_busy;
    @(posedge clk_sys) disable iff (!rst_n)
      state == SCS_CONV |-> start_conversion_bit;
  endproperty
  a_start_busy: assert property (p_start_busy) else $error("start bit low while busy"); // R11

  property p_start_clear;
    @(posedge clk_sys) disable iff (!rst_n)
      ce && conv_end && !free_run && converter_enable && !start_wr |=> !start_conversion_bit;
  endproperty
  a_start_clear: assert property (p_start_clear) else $error("start bit not cleared"); // R17

  property p_presc_reset;
    @(posedge clk_sys) disable iff (!rst_n)
      ce && !converter_enable |=> presc_cnt == '0 && !conv_clk;
  endproperty
  a_presc_reset: assert property (p_presc_reset) else $error("prescaler ran disabled"); // R12

  property p_sh_point;
    @(posedge clk_sys) disable iff (!rst_n)
      sample_hold |-> sh_mark == `SCS_HALF_SH_NORMAL || sh_mark == `SCS_HALF_SH_FIRST
                      || sh_mark == `SCS_HALF_SH_AUTO;
  endproperty
  a_sh_point: assert property (p_sh_point) else $error("sample at wrong instant"); // R16

  property p_pend_rise;
    @(posedge clk_sys) disable iff (!rst_n)
      state == SCS_PEND && ce && next_state == SCS_CONV |-> rise_tick;
  endproperty
  a_pend_rise: assert property (p_pend_rise) else $error("start off clock rise"); // R14

  property p_free_run;
    @(posedge clk_sys) disable iff (!rst_n)
      ce && conv_end && free_run && en_next |=> state == SCS_CONV && start_conversion_bit;
  endproperty
  a_free_run: assert property (p_free_run) else $error("free run stopped"); // R20

  property p_chan_frozen;
    @(posedge clk_sys) disable iff (!rst_n)
      ce && locked && converter_enable |=> $stable(channel_select);
  endproperty
  a_chan_frozen: assert property (p_chan_frozen) else $error("channel moved mid conversion"); // R6

  c_auto: cover property (@(posedge clk_sys) disable iff (!rst_n) auto_go ##[1:1000] conv_end);
  c_first: cover property (@(posedge clk_sys) disable iff (!rst_n)
    conv_end && conv_kind == 2'd1);
  c_lost: cover property (@(posedge clk_sys) disable iff (!rst_n) conv_end && result_lock);
  c_free: cover property (@(posedge clk_sys) disable iff (!rst_n)
    conv_end && free_run ##1 state == SCS_CONV);
endmodule

// ===== scs_params.svh
// Register map, field positions, reset values and timing counts of the converter sequencer
`ifndef SCS_PARAMS_SVH
`define SCS_PARAMS_SVH
`define SCS_OFF_CTRL 8'h00
`define SCS_OFF_SEL 8'h04
`define SCS_OFF_RES_LO 8'h08
`define SCS_OFF_RES_HI 8'h0C
`define SCS_OFF_SPECIAL 8'h10
`define SCS_CTRL_ENABLE 7
`define SCS_CTRL_START 6
`define SCS_CTRL_AUTO 5
`define SCS_CTRL_FLAG 4
`define SCS_CTRL_PRESC_LSB 0
`define SCS_SEL_REF_LSB 6
`define SCS_SEL_LEFT 5
`define SCS_SEL_CHAN_LSB 0
`define SCS_SPECIAL_TRIG_LSB 5
`define SCS_CTRL_RESET 8'h00
`define SCS_SEL_RESET 8'h00
`define SCS_SPECIAL_RESET 8'h00
`define SCS_SRC_FREE_RUN 3'h0
`define SCS_HALF_SH_NORMAL 6'h03
`define SCS_HALF_SH_FIRST 6'h1B
`define SCS_HALF_SH_AUTO 6'h04
`define SCS_HALF_END_NORMAL 6'h1A
`define SCS_HALF_END_FIRST 6'h32
`define SCS_HALF_END_AUTO 6'h1B
`define SCS_TRIG_SYNC_STAGES 3
`endif

// ===== scs_pkg.sv
// Types shared by the converter sequencer
package scs_pkg;
  typedef enum logic [2:0] {
    SCS_IDLE = 3'b001,
    SCS_PEND = 3'b010,
    SCS_CONV = 3'b100
  } scs_state_e;
  typedef logic [9:0] scs_result_t;
endpackage

// ===== scs_analog_model.sv
// Behavioural model of the analog sampling core behind the sequencer
`timescale 1ns/1ps
// ==========================================================================
// Analog core model
module scs_analog_model
  import scs_pkg::*;
(
  input wire logic clk_sys, // System clock
  input wire logic rst_n, // Synchronous reset, active low
  input wire logic sample_hold, // Sample instant from sequencer
  input wire logic conv_done, // Completion event
  input wire logic [4:0] channel_select, // Applied channel
  output scs_result_t sar_data // Conversion value
);
  logic held;
  scs_result_t val;
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      held <= 1'b0;
      val <= '0;
    end else if (sample_hold) begin
      val <= {channel_select, 5'h16};
      held <= 1'b1;
    end else if (conv_done) begin
      held <= 1'b0;
    end
  end
  // Before the sample instant or after the completion event the value is not valid, so show its inverse
  assign sar_data = held ? val : ~val;
endmodule

// ===== tb.sv
// Self-checking testbench of the converter sequencer
`timescale 1ns/1ps
`include "scs_params.svh"
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin n_mismatch++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (a), (e)); end end
// ==========================================================================
// Bench top
module tb;
  import scs_pkg::*;
  logic clk_sys, rst_n, ce, hsel, hwrite, hreadyout, hresp;
  logic conv_clk, sample_hold, conv_busy, conv_done;
  logic [7:0] haddr, trig_in;
  logic [1:0] htrans, reference_select;
  logic [2:0] hsize;
  logic [31:0] hwdata, hrdata, d;
  logic [4:0] channel_select;
  scs_result_t sar_data;
  int n_mismatch = 0, tests_run = 0, busy_n = 0, done_n = 0;
  scs_sequencer i_scs_sequencer (.clk_sys(clk_sys), .rst_n(rst_n), .ce(ce), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .trig_in(trig_in), .sar_data(sar_data), .conv_clk(conv_clk), .sample_hold(sample_hold),
    .conv_busy(conv_busy), .channel_select(channel_select),
    .reference_select(reference_select), .conv_done(conv_done));
  scs_analog_model i_scs_analog_model (.clk_sys(clk_sys), .rst_n(rst_n),
    .sample_hold(sample_hold), .conv_done(conv_done), .channel_select(channel_select),
    .sar_data(sar_data));
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    if (conv_busy === 1'b1) busy_n++;
    if (conv_done === 1'b1) done_n++;
  end
  function automatic scs_result_t mval(input logic [4:0] ch);
    return {ch, 5'h16};
  endfunction
  // ========================================================================
  // Bus tasks
  task automatic xfer(input logic [7:0] a, input logic wr, input logic [31:0] wd);
    @(posedge clk_sys);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= wr;
    htrans <= 2'h2;
    @(posedge clk_sys);
    while (hreadyout !== 1'b1) @(posedge clk_sys);
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge clk_sys);
    while (hreadyout !== 1'b1) @(posedge clk_sys);
    d = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    xfer(a, 1'b1, {24'h00_0000, v});
  endtask
  task automatic rd(input logic [7:0] a);
    xfer(a, 1'b0, 32'h0000_0000);
  endtask
  task automatic wait_done();
    int k;
    k = 0;
    while (conv_done !== 1'b1 && k < 2000) begin
      @(posedge clk_sys);
      k++;
    end
    if (k >= 2000) n_mismatch++;
  endtask
  task automatic convert(input logic [7:0] cmd);
    busy_n = 0;
    wr(`SCS_OFF_CTRL, cmd);
    wait_done();
    repeat (2) @(posedge clk_sys);
  endtask
  // ========================================================================
  // Scenarios
  task automatic t_reset();
    rd(`SCS_OFF_CTRL); `CHK(d, 32'h0000_0000)
    rd(`SCS_OFF_SEL); `CHK(d, 32'h0000_0000)
    rd(`SCS_OFF_SPECIAL); `CHK(d, 32'h0000_0000)
    rd(8'h20); `CHK(d, 32'h0000_0000)
    `CHK(hresp, 1'b0)
  endtask
  task automatic t_enable();
    int r;
    logic c;
    wr(`SCS_OFF_SEL, 8'h13);
    repeat (6) @(posedge clk_sys);
    `CHK(channel_select, 5'h00)
    `CHK(conv_clk, 1'b0)
    wr(`SCS_OFF_CTRL, 8'h80);
    r = 0;
    repeat (20) begin
      @(posedge clk_sys);
      if (conv_clk === 1'b1) r++;
    end
    `CHK(r inside {[9:11]}, 1'b1)
    `CHK(channel_select, 5'h13)
    ce <= 1'b0;
    @(posedge clk_sys);
    c = conv_clk;
    repeat (5) @(posedge clk_sys);
    `CHK(conv_clk, c)
    ce <= 1'b1;
  endtask
  task automatic t_single();
    wr(`SCS_OFF_CTRL, 8'hC0);
    rd(`SCS_OFF_CTRL); `CHK(d[6], 1'b1)
    wait_done();
    repeat (2) @(posedge clk_sys);
    `CHK(busy_n inside {[48:52]}, 1'b1)
    rd(`SCS_OFF_CTRL); `CHK(d[6:4], 3'b001)
    rd(`SCS_OFF_RES_LO); `CHK(d[7:0], mval(5'h13) & 8'hFF)
    rd(`SCS_OFF_RES_HI); `CHK(d[7:0], {6'h00, mval(5'h13) >> 8})
    wr(`SCS_OFF_SEL, 8'h33);
    convert(8'hD0);
    `CHK(busy_n inside {[24:28]}, 1'b1)
    rd(`SCS_OFF_RES_HI); `CHK(d[7:0], mval(5'h13) >> 2)
  endtask
  task automatic t_lock();
    rd(`SCS_OFF_RES_LO);
    wr(`SCS_OFF_SEL, 8'h0C);
    done_n = 0;
    convert(8'hD0);
    `CHK(done_n, 1)
    rd(`SCS_OFF_RES_LO); `CHK(d[7:0], {mval(5'h13) & 2'h3, 6'h00})
    rd(`SCS_OFF_RES_HI); `CHK(d[7:0], mval(5'h13) >> 2)
    convert(8'hD0);
    rd(`SCS_OFF_RES_LO); `CHK(d[7:0], mval(5'h0C) & 8'hFF)
    rd(`SCS_OFF_RES_HI);
  endtask
  task automatic t_chan();
    wr(`SCS_OFF_CTRL, 8'hD0);
    wr(`SCS_OFF_SEL, 8'hC1);
    `CHK(channel_select, 5'h0C)
    `CHK(reference_select, 2'h0)
    wait_done();
    repeat (3) @(posedge clk_sys);
    `CHK(channel_select, 5'h01)
    `CHK(reference_select, 2'h3)
    rd(`SCS_OFF_RES_LO); `CHK(d[7:0], mval(5'h0C) & 8'hFF)
    rd(`SCS_OFF_RES_HI);
  endtask
  task automatic t_auto();
    int k;
    wr(`SCS_OFF_SPECIAL, 8'h40);
    wr(`SCS_OFF_CTRL, 8'hB0);
    done_n = 0;
    @(posedge clk_sys) trig_in <= 8'h04;
    k = 0;
    while (sample_hold !== 1'b1 && k < 40) begin
      @(posedge clk_sys);
      k++;
    end
    `CHK(k inside {[4:12]}, 1'b1)
    trig_in <= 8'h00;
    @(posedge clk_sys) trig_in <= 8'h04;
    repeat (80) @(posedge clk_sys);
    `CHK(done_n, 1)
    wr(`SCS_OFF_CTRL, 8'hB0);
    trig_in <= 8'h00;
    @(posedge clk_sys) trig_in <= 8'h04;
    repeat (60) @(posedge clk_sys);
    `CHK(done_n, 2)
    convert(8'hF0);
    `CHK(done_n, 3)
    trig_in <= 8'h00;
  endtask
  task automatic t_free();
    int r;
    wr(`SCS_OFF_SPECIAL, 8'h00);
    done_n = 0;
    wr(`SCS_OFF_CTRL, 8'hE0);
    repeat (150) @(posedge clk_sys);
    `CHK(done_n inside {[4:6]}, 1'b1)
    rd(`SCS_OFF_CTRL); `CHK(d[6], 1'b1)
    wr(`SCS_OFF_CTRL, 8'h00);
    repeat (4) @(posedge clk_sys);
    `CHK({conv_busy, conv_clk}, 2'b00)
    wr(`SCS_OFF_CTRL, 8'h87);
    r = 0;
    repeat (1024) begin
      @(posedge clk_sys);
      if (conv_clk === 1'b1) r++;
    end
    `CHK(r, 384)
  endtask
  // ========================================================================
  // Verdict
  task automatic complete_run();
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    rst_n = 1'b0;
    ce = 1'b1;
    hsel = 1'b0;
    haddr = 8'h00;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0000_0000;
    trig_in = 8'h00;
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    `CHK(hreadyout, 1'b1)
    t_reset();
    t_enable();
    t_single();
    t_lock();
    t_chan();
    t_auto();
    t_free();
    complete_run();
  end
  initial begin
    #500000;
    n_mismatch++;
    complete_run();
  end
endmodule
